// File: dv/bus_memory_model.sv
`default_nettype none
module bus_memory_model (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // Test control
    input  wire logic        slow,
    // System bus
    input  wire logic [11:0] low_address_lines,
    input  wire logic [7:0]  data_out,
    input  wire logic        address_strobe_n,
    input  wire logic        read_strobe_n,
    input  wire logic        read_strobe_oe,
    input  wire logic        write_strobe_n,
    input  wire logic        write_strobe_oe,
    output logic [7:0]       data_in,
    output logic             cycle_extend_n,
    // Latched full address and status
    output logic [15:0]      lat_addr,
    output logic [3:0]       lat_stat
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:255];
    logic [7:0] last_q = 8'h00;
    logic [7:0] idx;
    logic       rd_on;
    logic       wr_on;
    int         low_cnt = 0;
    assign idx   = {lat_addr[15:12], lat_addr[3:0]};
    assign rd_on = !read_strobe_n && read_strobe_oe;
    assign wr_on = !write_strobe_n && write_strobe_oe;
    // Released bus shows inverse of last value
    assign data_in        = rd_on ? mem[idx] : ~last_q;
    // Extend pulled low from the address phase on, ahead of the strobe's trailing edge
    assign cycle_extend_n = !(slow && (!address_strobe_n || rd_on || wr_on)
                              && low_cnt < 12);
    initial
    begin
        lat_addr = 16'h0000;
        lat_stat = 4'h0;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    end
    always @(posedge clock)
    begin
        if (!address_strobe_n)
        begin
            lat_addr <= {data_out[3:0], low_address_lines};
            lat_stat <= data_out[7:4];
        end
        if (wr_on) mem[idx] <= data_out;
        if (rd_on) last_q <= mem[idx];
        low_cnt <= (rstn && (!address_strobe_n || rd_on || wr_on)) ? low_cnt + 1 : 0;
    end
endmodule
`default_nettype wire

// File: dv/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------------
    // Signals
    // --------------------------------------------------------
    logic                  clock = 1'b0;
    logic                  rstn = 1'b0;
    logic                  req_valid = 1'b0;
    cpu_bus_pkg::bus_req_t req = '0;
    logic                  shift_cmd = 1'b0;
    logic                  load_cmd = 1'b0;
    logic [7:0]            load_data = 8'h00;
    logic                  serial_in_line = 1'b0;
    logic                  slow = 1'b0;
    logic                  req_ready, rsp_valid, low_address_oe, data_oe, address_strobe_n;
    logic                  read_strobe_n, read_strobe_oe, write_strobe_n, write_strobe_oe;
    logic                  cycle_extend_n, serial_out_line;
    logic [7:0]            rsp_rdata, e_value, data_out, data_in;
    logic [11:0]           low_address_lines;
    logic [15:0]           lat_addr;
    logic [3:0]            lat_stat;
    logic [7:0]            ref_mem [0:255];
    logic [15:0]           rnd = 16'h0016;
    int                    err_total = 0;
    int                    cmp_count = 0;
    always #5 clock = ~clock;
    cpu_system_bus_cycle cpu_system_bus_cycle_i (.clock(clock), .rstn(rstn),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .shift_cmd(shift_cmd), .load_cmd(load_cmd),
        .load_data(load_data), .e_value(e_value), .low_address_lines(low_address_lines),
        .low_address_oe(low_address_oe), .data_out(data_out), .data_oe(data_oe),
        .data_in(data_in), .address_strobe_n(address_strobe_n),
        .read_strobe_n(read_strobe_n), .read_strobe_oe(read_strobe_oe),
        .write_strobe_n(write_strobe_n), .write_strobe_oe(write_strobe_oe),
        .cycle_extend_n(cycle_extend_n), .serial_in_line(serial_in_line),
        .serial_out_line(serial_out_line));
    bus_memory_model bus_memory_model_i (.clock(clock), .rstn(rstn), .slow(slow),
        .low_address_lines(low_address_lines), .data_out(data_out),
        .address_strobe_n(address_strobe_n), .read_strobe_n(read_strobe_n),
        .read_strobe_oe(read_strobe_oe), .write_strobe_n(write_strobe_n),
        .write_strobe_oe(write_strobe_oe), .data_in(data_in),
        .cycle_extend_n(cycle_extend_n), .lat_addr(lat_addr), .lat_stat(lat_stat));
    // --------------------------------------------------------
    // Helpers
    // --------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // One bus cycle, entered at a falling edge
    task automatic bus_op(input logic wr, input logic [15:0] a, input logic [3:0] st,
                          input logic [7:0] wd);
        int         n;
        int         lat;
        logic [7:0] idx;
        idx = {a[15:12], a[3:0]};
        lat = cpu_bus_pkg::CLK_PER_TICK * (cpu_bus_pkg::ADDR_TICKS
              + (wr ? cpu_bus_pkg::WR_TICKS : cpu_bus_pkg::RD_TICKS));
        req = '{addr: a, status: st, wdata: wd, write: wr};
        req_valid = 1'b1;
        while (req_ready !== 1'b1) @(negedge clock);
        @(negedge clock);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 64)
        begin
            @(negedge clock);
            n++;
        end
        if (slow)
            chk_val("stretch", 16'h0001, {15'h0000, n > lat});
        else
            chk_val("latency", 16'(lat), 16'(n));
        chk_val("full_addr", a, lat_addr);
        chk_val("status", {12'h000, st}, {12'h000, lat_stat});
        if (wr)
            ref_mem[idx] = wd;
        else
            chk_val("rdata", {8'h00, ref_mem[idx]}, {8'h00, rsp_rdata});
    endtask
    task automatic run_cycles(input string tname);
        logic [15:0] a;
        for (int i = 0; i < 14; i++)
        begin
            rnd = lfsr_next(rnd);
            a = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : rnd;
            rnd = lfsr_next(rnd);
            bus_op(1'b1, a, rnd[3:0], rnd[11:4]);
            bus_op(1'b0, a, rnd[15:12], 8'h00);
            bus_op(1'b0, a ^ 16'hF00F, 4'hF, 8'h00);
        end
        $display("test %s done, errors %0d", tname, err_total);
    endtask
    task automatic serial_test();
        logic [7:0] e_exp;
        logic       b;
        logic       prev;
        prev = 1'b0;
        rnd = lfsr_next(rnd);
        e_exp = rnd[7:0];
        load_data = e_exp;
        load_cmd = 1'b1;
        @(negedge clock);
        load_cmd = 1'b0;
        chk_val("e_load", {8'h00, e_exp}, {8'h00, e_value});
        repeat (8)
        begin
            rnd = lfsr_next(rnd);
            b = rnd[0];
            serial_in_line = b;
            repeat (3) @(negedge clock);
            chk_val("serial_out_line_idle", {15'h0000, prev}, {15'h0000, serial_out_line});
            shift_cmd = 1'b1;
            @(negedge clock);
            shift_cmd = 1'b0;
            chk_val("serial_out_line", {15'h0000, e_exp[0]}, {15'h0000, serial_out_line});
            prev = e_exp[0];
            e_exp = {b, e_exp[7:1]};
            chk_val("e_shift", {8'h00, e_exp}, {8'h00, e_value});
        end
        $display("test serial done, errors %0d", err_total);
    endtask
    // --------------------------------------------------------
    // Wire watch
    // --------------------------------------------------------
    always @(negedge clock)
    begin
        if (rstn && !read_strobe_n && read_strobe_oe)
            chk_val("rd_bus", 16'h0002, {14'h0000, low_address_oe, data_oe});
        if (rstn && !write_strobe_n && write_strobe_oe)
            chk_val("wr_bus", 16'h0003, {14'h0000, low_address_oe, data_oe});
        if (rstn && !address_strobe_n)
            chk_val("adr_bus", 16'h0003, {14'h0000, low_address_oe, data_oe});
    end
    initial
    begin
        #100000;
        err_total++;
        final_report();
    end
    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial
    begin
        for (int i = 0; i < 256; i++) ref_mem[i] = 8'(i) ^ 8'h5A;
        repeat (12) @(negedge clock);
        chk_val("reset_pins", 16'h0018, {11'h000, address_strobe_n, req_ready, data_oe,
                read_strobe_oe, write_strobe_oe});
        rstn = 1'b1;
        @(negedge clock);
        run_cycles("fast");
        slow = 1'b1;
        run_cycles("slow");
        slow = 1'b0;
        serial_test();
        final_report();
    end
endmodule
`default_nettype wire

// File: logic/cpu_bus_pkg.sv
`default_nettype none
package cpu_bus_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W     = 16;
    localparam int LOW_ADDR_W = 12;
    localparam int HI_ADDR_W  = 4;
    localparam int STAT_W     = 4;
    localparam int DATA_W     = 8;
    localparam int CNT_W      = 3;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS       = 10;
    localparam int CLK_PER_TICK = 2;
    localparam int TC_NS        = CLK_NS * CLK_PER_TICK;
    localparam int RD_W_NS      = TC_NS + 50;
    localparam int WR_W_NS      = TC_NS;
    localparam int ADDR_TICKS   = 1;
    localparam int RD_TICKS     = (RD_W_NS + TC_NS - 1) / TC_NS;
    localparam int WR_TICKS     = (WR_W_NS + TC_NS - 1) / TC_NS;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ADDR = 2'h1,
        ST_XFER = 2'h3,
        ST_DONE = 2'h2
    } bus_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [STAT_W-1:0] status;
        logic [DATA_W-1:0] wdata;
        logic              write;
    } bus_req_t;
endpackage
`default_nettype wire

// File: logic/cpu_system_bus_cycle.sv
`default_nettype none
module cpu_system_bus_cycle #(
    parameter int ADDR_TICKS = cpu_bus_pkg::ADDR_TICKS,
    parameter int RD_TICKS   = cpu_bus_pkg::RD_TICKS,
    parameter int WR_TICKS   = cpu_bus_pkg::WR_TICKS
) (
    // Clock and reset
    input  wire logic                               clock,
    input  wire logic                               rstn,
    // Bus cycle request
    input  wire logic                               req_valid,
    output logic                                    req_ready,
    input  wire cpu_bus_pkg::bus_req_t              req,
    // Bus cycle answer
    output logic                                    rsp_valid,
    output logic [cpu_bus_pkg::DATA_W-1:0]          rsp_rdata,
    // Serial control
    input  wire logic                               shift_cmd,
    input  wire logic                               load_cmd,
    input  wire logic [cpu_bus_pkg::DATA_W-1:0]     load_data,
    output logic [cpu_bus_pkg::DATA_W-1:0]          e_value,
    // Address bus pins
    output logic [cpu_bus_pkg::LOW_ADDR_W-1:0]      low_address_lines,
    output logic                                    low_address_oe,
    // Data bus pins
    output logic [cpu_bus_pkg::DATA_W-1:0]          data_out,
    output logic                                    data_oe,
    input  wire logic [cpu_bus_pkg::DATA_W-1:0]     data_in,
    // Strobe pins
    output logic                                    address_strobe_n,
    output logic                                    read_strobe_n,
    output logic                                    read_strobe_oe,
    output logic                                    write_strobe_n,
    output logic                                    write_strobe_oe,
    input  wire logic                               cycle_extend_n,
    // Serial pins
    input  wire logic                               serial_in_line,
    output logic                                    serial_out_line
);
    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (ADDR_TICKS < 1 || RD_TICKS < 1 || WR_TICKS < 1) begin : g_bad_min
        $error("Phase lengths must be at least one tick");
    end
    if (ADDR_TICKS > 2**cpu_bus_pkg::CNT_W || RD_TICKS > 2**cpu_bus_pkg::CNT_W
        || WR_TICKS > 2**cpu_bus_pkg::CNT_W) begin : g_bad_max
        $error("Phase length exceeds tick counter");
    end

    localparam int DIV_W = $clog2(cpu_bus_pkg::CLK_PER_TICK);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(cpu_bus_pkg::CLK_PER_TICK - 1);
    localparam logic [cpu_bus_pkg::CNT_W-1:0] CNT_ADDR = cpu_bus_pkg::CNT_W'(ADDR_TICKS - 1);
    localparam logic [cpu_bus_pkg::CNT_W-1:0] CNT_RD   = cpu_bus_pkg::CNT_W'(RD_TICKS - 1);
    localparam logic [cpu_bus_pkg::CNT_W-1:0] CNT_WR   = cpu_bus_pkg::CNT_W'(WR_TICKS - 1);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic                              ext_s1_q;
    logic                              ext_s2_q;
    logic                              sin_s1_q;
    logic                              sin_s2_q;
    logic [cpu_bus_pkg::DATA_W-1:0]    din_s1_q;
    logic [cpu_bus_pkg::DATA_W-1:0]    din_s2_q;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            ext_s1_q <= 1'b1;
            ext_s2_q <= 1'b1;
            sin_s1_q <= 1'b0;
            sin_s2_q <= 1'b0;
            din_s1_q <= '0;
            din_s2_q <= '0;
        end
        else
        begin
            ext_s1_q <= cycle_extend_n;
            ext_s2_q <= ext_s1_q;
            sin_s1_q <= serial_in_line;
            sin_s2_q <= sin_s1_q;
            din_s1_q <= data_in;
            din_s2_q <= din_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Bus cycle sequencer
    // ------------------------------------------------------------
    cpu_bus_pkg::bus_state_t             state_q, state_d;
    logic [DIV_W-1:0]                    div_q, div_d;
    logic [cpu_bus_pkg::CNT_W-1:0]       cnt_q, cnt_d;
    cpu_bus_pkg::bus_req_t               cur_q, cur_d;
    logic                                rsp_valid_q, rsp_valid_d;
    logic [cpu_bus_pkg::DATA_W-1:0]      rdata_q, rdata_d;
    logic                                tick;
    logic                                accept;

    assign req_ready = (state_q == cpu_bus_pkg::ST_IDLE);
    assign accept    = req_valid && req_ready;
    assign tick      = (div_q == DIV_LAST);

    always_comb
    begin
        state_d     = state_q;
        cnt_d       = cnt_q;
        cur_d       = cur_q;
        rdata_d     = rdata_q;
        rsp_valid_d = 1'b0;
        // Divide by two, phase aligned to each cycle start
        div_d       = accept ? '0 : div_q + DIV_W'(1);
        unique case (state_q)
            cpu_bus_pkg::ST_IDLE:
            begin
                if (accept)
                begin
                    cur_d   = req;
                    cnt_d   = CNT_ADDR;
                    state_d = cpu_bus_pkg::ST_ADDR;
                end
            end
            cpu_bus_pkg::ST_ADDR:
            begin
                if (tick)
                begin
                    if (cnt_q == '0)
                    begin
                        cnt_d   = cur_q.write ? CNT_WR : CNT_RD;
                        state_d = cpu_bus_pkg::ST_XFER;
                    end
                    else
                    begin
                        cnt_d = cnt_q - cpu_bus_pkg::CNT_W'(1);
                    end
                end
            end
            cpu_bus_pkg::ST_XFER:
            begin
                if (tick && cnt_q != '0)
                begin
                    cnt_d = cnt_q - cpu_bus_pkg::CNT_W'(1);
                end
                // Extend input held low keeps the strobe asserted
                else if (tick && ext_s2_q)
                begin
                    state_d     = cpu_bus_pkg::ST_DONE;
                    rsp_valid_d = 1'b1;
                    if (!cur_q.write)
                    begin
                        rdata_d = din_s2_q;
                    end
                end
            end
            cpu_bus_pkg::ST_DONE:
            begin
                if (tick)
                begin
                    state_d = cpu_bus_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q     <= cpu_bus_pkg::ST_IDLE;
            div_q       <= '0;
            cnt_q       <= '0;
            cur_q       <= '0;
            rsp_valid_q <= 1'b0;
            rdata_q     <= '0;
        end
        else
        begin
            state_q     <= state_d;
            div_q       <= div_d;
            cnt_q       <= cnt_d;
            cur_q       <= cur_d;
            rsp_valid_q <= rsp_valid_d;
            rdata_q     <= rdata_d;
        end
    end

    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rdata_q;

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    logic in_addr;
    logic in_xfer;
    logic in_cycle;

    assign in_addr  = (state_q == cpu_bus_pkg::ST_ADDR);
    assign in_xfer  = (state_q == cpu_bus_pkg::ST_XFER);
    assign in_cycle = (state_q != cpu_bus_pkg::ST_IDLE);

    assign low_address_lines = cur_q.addr[cpu_bus_pkg::LOW_ADDR_W-1:0];
    assign low_address_oe    = in_addr || in_xfer;
    assign data_out = in_addr ?
        {cur_q.status, cur_q.addr[cpu_bus_pkg::ADDR_W-1:cpu_bus_pkg::LOW_ADDR_W]}
        : cur_q.wdata;
    // Read phase leaves the data bus to the responder
    assign data_oe          = in_addr || (cur_q.write && in_cycle);
    assign address_strobe_n = !in_addr;
    assign read_strobe_n    = !(in_xfer && !cur_q.write);
    assign read_strobe_oe   = in_cycle && !cur_q.write;
    assign write_strobe_n   = !(in_xfer && cur_q.write);
    assign write_strobe_oe  = in_cycle && cur_q.write;

    // ------------------------------------------------------------
    // Serial shift register
    // ------------------------------------------------------------
    logic [cpu_bus_pkg::DATA_W-1:0] e_q, e_d;
    logic                           serial_out_line_q, serial_out_line_d;

    always_comb
    begin
        e_d    = e_q;
        serial_out_line_d = serial_out_line_q;
        if (shift_cmd)
        begin
            serial_out_line_d = e_q[0];
            e_d    = {sin_s2_q, e_q[cpu_bus_pkg::DATA_W-1:1]};
        end
        else if (load_cmd)
        begin
            e_d = load_data;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            e_q    <= '0;
            serial_out_line_q <= 1'b0;
        end
        else
        begin
            e_q    <= e_d;
            serial_out_line_q <= serial_out_line_d;
        end
    end

    assign e_value         = e_q;
    assign serial_out_line = serial_out_line_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    addr_phase_drive_a: assert property (!address_strobe_n |-> low_address_oe && data_oe)
        else $error("Address strobe without driven buses");
    addr_content_a: assert property (!address_strobe_n |-> low_address_lines
        == cur_q.addr[cpu_bus_pkg::LOW_ADDR_W-1:0] && data_out == {cur_q.status,
        cur_q.addr[cpu_bus_pkg::ADDR_W-1:cpu_bus_pkg::LOW_ADDR_W]})
        else $error("Address phase content wrong");
    addr_width_a: assert property ($fell(address_strobe_n) |=> !address_strobe_n ##1
        address_strobe_n)
        else $error("Address strobe not one timing unit");
    strobe_order_a: assert property ($fell(read_strobe_n) || $fell(write_strobe_n) |->
        $past(!address_strobe_n))
        else $error("Data strobe without preceding address phase");
    read_width_a: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*8])
        else $error("Read strobe shorter than minimum");
    read_no_drive_a: assert property (!read_strobe_n |-> !data_oe && read_strobe_oe)
        else $error("Data bus driven during read");
    extend_hold_a: assert property (in_xfer && !ext_s2_q |=> in_xfer)
        else $error("Strobe released while extend low");
    addr_float_a: assert property ($rose(read_strobe_n) || $rose(write_strobe_n) |->
        !low_address_oe)
        else $error("Address bus driven after trailing edge");
    addr_stable_a: assert property (low_address_oe && $past(low_address_oe) |->
        $stable(low_address_lines))
        else $error("Address changed while valid");
    write_data_a: assert property (!write_strobe_n |-> data_oe && data_out == cur_q.wdata)
        else $error("Write strobe without write data");
    idle_float_a: assert property (!in_cycle |-> !read_strobe_oe && !write_strobe_oe)
        else $error("Strobes driven outside a cycle");
    serial_shift_a: assert property (shift_cmd |=> serial_out_line == $past(e_q[0]))
        else $error("Serial output not shifted");
    serial_hold_a: assert property (!shift_cmd |=> $stable(serial_out_line))
        else $error("Serial output moved without command");

    read_cycle_c: cover property ($fell(read_strobe_n) ##[1:20] rsp_valid);
    write_cycle_c: cover property ($fell(write_strobe_n) ##[1:20] rsp_valid);
    extended_c: cover property (in_xfer && !ext_s2_q ##[1:30] $rose(read_strobe_n));
    serial_c: cover property (shift_cmd ##1 shift_cmd);
endmodule
`default_nettype wire
